// ### host_link_interrupt_event_low.sv
// Lower half of the link interrupt event register with mask and output
//
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps

// Notes on behaviour
// - Set 64-second tick when watched cycle seconds bit changes.
// - Set new cycle flag when cycle count low bit toggles.
// - Set PHY request flag on a PHY status interrupt request.
// - Access without link clock sets failure flag before next access.
// - Set bus reset flag when PHY enters bus reset.
// - Set node ident done flag when self-ID stream completes.
// - Node ident done clears in the cycle bus reset becomes set.
// - Sticky ident done sets with primary, ignores bus reset.
// - Bits 14 down to 10 always read as zero.
// - Set lock response error when lock response lacks ack_complete.
// - Set posted write error on host bus error during posted write.
// - Transmit summary is unlatched OR of masked per-context events.
// - Set response packet flag after response packet is stored.
// - Set request packet flag after request packet is stored.
// - Conditionally set receive response DMA flag on completion.
// - Conditionally set receive request DMA flag on completion.
// - Conditionally set response transmit done flag on completion.
// - Conditionally set request transmit done flag on completion.
// - Event interrupts only while its mask bit is one.
// - Global enable clear blocks the interrupt output entirely.
module host_link_interrupt_event_low
    import host_link_irq_pkg::*;
#(
    parameter int ISO_RX_CTX = 8,
    parameter int ISO_TX_CTX = 8
) (
    input wire logic I_CLK_SYS,
    input wire logic I_RST_N,
    input wire logic [ADDR_W-1:0] I_ADDR,
    input wire logic [DATA_W-1:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [DATA_W-1:0] O_RDATA,
    input wire event_strobes_t I_EVT,
    input wire logic [SECONDS_W-1:0] I_CYCLE_SECONDS_COUNTER,
    input wire logic [COUNT_W-1:0] I_CYCLE_NUMBER_COUNTER,
    input wire logic I_LINK_CLOCK_PRESENT,
    input wire logic [ISO_RX_CTX-1:0] I_ISO_RX_EVENT,
    input wire logic [ISO_RX_CTX-1:0] I_ISO_RX_MASK,
    input wire logic [ISO_TX_CTX-1:0] I_ISO_TX_EVENT,
    input wire logic [ISO_TX_CTX-1:0] I_ISO_TX_MASK,
    output logic O_IRQ,
    output logic [EVT_W-1:0] O_EVENTS
);

    // Address match used by every decode
    function automatic logic addr_hit(input logic [7:0] a,
                                      input logic [7:0] off);
        addr_hit = (a == off);
    endfunction : addr_hit

    reg_req_t req;
    assign req = '{addr: I_ADDR, wdata: I_WDATA, wr: I_WR, rd: I_RD};

    logic [EVT_W-1:0] event_q;
    logic [EVT_W-1:0] event_d;
    logic [EVT_W-1:0] mask_q;
    logic global_en_q;
    logic [EVT_W-1:0] hw_set;
    logic [EVT_W-1:0] sw_set;
    logic [EVT_W-1:0] sw_clr;
    logic [EVT_W-1:0] view;
    logic [DATA_W-1:0] rdata_q;
    logic irq_q;
    logic link_sync1_q;
    logic link_sync2_q;
    logic [SECONDS_W-1:0] seconds_prev_q;
    logic [COUNT_W-1:0] count_prev_q;
    logic timer_valid_q;
    logic access_fail;
    logic bus_reset_rise;
    logic iso_rx_sum;
    logic iso_tx_sum;
    logic [ASYNC_CTX-1:0] ctx_fire;

    // Link clock presence pin synchroniser
    always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
        if (!I_RST_N) begin
            link_sync1_q <= 1'b0;
            link_sync2_q <= 1'b0;
        end else begin
            link_sync1_q <= I_LINK_CLOCK_PRESENT;
            link_sync2_q <= link_sync1_q;
        end
    end

    // Previous cycle timer values for change detection
    always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
        if (!I_RST_N) begin
            seconds_prev_q <= '0;
            count_prev_q <= '0;
            timer_valid_q <= 1'b0;
        end else begin
            seconds_prev_q <= I_CYCLE_SECONDS_COUNTER;
            count_prev_q <= I_CYCLE_NUMBER_COUNTER;
            timer_valid_q <= 1'b1;
        end
    end

    // Register access while the link clock is absent
    assign access_fail = (req.wr | req.rd) & ~link_sync2_q;

    // Conditional DMA completion
    assign ctx_fire = I_EVT.ctx_done & I_EVT.ctx_irq_req;

    // Unlatched isochronous summaries
    assign iso_rx_sum = |(I_ISO_RX_EVENT & I_ISO_RX_MASK);
    assign iso_tx_sum = |(I_ISO_TX_EVENT & I_ISO_TX_MASK);

    // Hardware event sources
    always_comb begin
        hw_set = '0;
        hw_set[B_SIXTY_FOUR_SECOND_TICK] = timer_valid_q &
            (I_CYCLE_SECONDS_COUNTER[SECONDS_WATCH_BIT] !=
             seconds_prev_q[SECONDS_WATCH_BIT]);
        hw_set[B_NEW_ISO_CYCLE_FLAG] = timer_valid_q &
            (I_CYCLE_NUMBER_COUNTER[COUNT_WATCH_BIT] !=
             count_prev_q[COUNT_WATCH_BIT]);
        hw_set[B_PHY_REQUEST] = I_EVT.phy_request;
        hw_set[B_REGISTER_ACCESS_FAILURE] = access_fail;
        hw_set[B_BUS_RESET_ENTERED] = I_EVT.bus_reset_entered;
        hw_set[B_NODE_IDENT_DONE] = I_EVT.node_ident_done;
        hw_set[B_NODE_IDENT_DONE_STICKY] = I_EVT.node_ident_done;
        hw_set[B_LOCK_RESPONSE_ERROR] = I_EVT.lock_response_error;
        hw_set[B_POSTED_WRITE_ERROR] = I_EVT.posted_write_error;
        hw_set[B_RESPONSE_PACKET_STORED] =
            I_EVT.response_packet_stored;
        hw_set[B_REQUEST_PACKET_STORED] =
            I_EVT.request_packet_stored;
        hw_set[B_ASYNC_RX_RESPONSE_CONTEXT] = ctx_fire[3];
        hw_set[B_ASYNC_RX_REQUEST_CONTEXT] = ctx_fire[2];
        hw_set[B_RESPONSE_TRANSMIT_DONE] = ctx_fire[1];
        hw_set[B_REQUEST_TRANSMIT_DONE] = ctx_fire[0];
    end

    // Software set and clear strobes
    assign sw_set = (req.wr && addr_hit(req.addr, OFF_EVENT_SET)) ?
        req.wdata[EVT_W-1:0] : '0;
    assign sw_clr = (req.wr && addr_hit(req.addr, OFF_EVENT_CLR)) ?
        req.wdata[EVT_W-1:0] : '0;

    // Per-bit next state; set wins over clear
    genvar gi;
    generate
        for (gi = 0; gi < EVT_W; gi++) begin : g_evt
            if (LATCHED_BITS[gi]) begin : g_latched
                assign event_d[gi] = hw_set[gi] | sw_set[gi] |
                    (event_q[gi] & ~sw_clr[gi]);
            end else begin : g_none
                assign event_d[gi] = 1'b0;
            end
        end
    endgenerate

    // Bus reset flag turning on
    assign bus_reset_rise = event_d[B_BUS_RESET_ENTERED] &
        ~event_q[B_BUS_RESET_ENTERED];

    // Event register store
    always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
        if (!I_RST_N) begin
            event_q <= EVENT_RESET;
        end else begin
            event_q <= event_d;
            if (bus_reset_rise) begin
                event_q[B_NODE_IDENT_DONE] <= 1'b0;
            end
        end
    end

    // Mask register and global enable
    always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
        if (!I_RST_N) begin
            mask_q <= MASK_RESET;
            global_en_q <= 1'b0;
        end else if (req.wr && addr_hit(req.addr, OFF_MASK_SET)) begin
            mask_q <= mask_q | (req.wdata[EVT_W-1:0] & MASK_BITS);
            if (req.wdata[B_GLOBAL_INTERRUPT_ENABLE]) begin
                global_en_q <= 1'b1;
            end
        end else if (req.wr && addr_hit(req.addr, OFF_MASK_CLR)) begin
            mask_q <= mask_q & ~req.wdata[EVT_W-1:0];
            if (req.wdata[B_GLOBAL_INTERRUPT_ENABLE]) begin
                global_en_q <= 1'b0;
            end
        end
    end

    // Full event view with unlatched summaries
    always_comb begin
        view = event_q & LATCHED_BITS;
        view[B_ISO_RECEIVE_SUMMARY] = iso_rx_sum;
        view[B_ISO_TRANSMIT_SUMMARY] = iso_tx_sum;
    end

    // Read data, one cycle after the read strobe
    always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
        if (!I_RST_N) begin
            rdata_q <= RDATA_IDLE;
        end else if (req.rd) begin
            rdata_q <= RDATA_IDLE;
            if (addr_hit(req.addr, OFF_EVENT_SET)) begin
                rdata_q[EVT_W-1:0] <= view;
            end else if (addr_hit(req.addr, OFF_EVENT_CLR)) begin
                rdata_q[EVT_W-1:0] <= view & mask_q;
            end else if (addr_hit(req.addr, OFF_MASK_SET) ||
                         addr_hit(req.addr, OFF_MASK_CLR)) begin
                rdata_q[EVT_W-1:0] <= mask_q;
                rdata_q[B_GLOBAL_INTERRUPT_ENABLE] <= global_en_q;
            end
        end else begin
            rdata_q <= RDATA_IDLE;
        end
    end

    // Interrupt output
    always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
        if (!I_RST_N) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= global_en_q &
                (|(view & mask_q));
        end
    end

    assign O_RDATA = rdata_q;
    assign O_IRQ = irq_q;
    assign O_EVENTS = event_q;

endmodule : host_link_interrupt_event_low

// ### host_link_interrupt_event_low_tb_top.sv
// Self-checking testbench for the link interrupt event block
`timescale 1ns/10ps
module host_link_interrupt_event_low_tb_top
    import host_link_irq_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic [14:0] evt = 15'h0;
    logic [6:0] sec = 7'h00;
    logic [12:0] cnt = 13'h0;
    logic link_ok = 1'b1;
    logic [7:0] rx_ev = 8'h00;
    logic [7:0] rx_mk = 8'h00;
    logic [7:0] tx_ev = 8'h00;
    logic [7:0] tx_mk = 8'h00;
    logic irq;
    logic [21:0] evs;
    int n_errors = 0;
    int check_count = 0;
    logic [14:0] stim [12] = '{15'h4000, 15'h2000, 15'h1000, 15'h0800,
        15'h0400, 15'h0200, 15'h0100, 15'h0088, 15'h0044, 15'h0022,
        15'h0011, 15'h00F0};
    logic [21:0] expv [12] = '{22'h080000, 22'h020000, 22'h018000,
        22'h000200, 22'h000100, 22'h000020, 22'h000010, 22'h000008,
        22'h000004, 22'h000002, 22'h000001, 22'h000000};

    always #5 clk = ~clk;

    host_link_interrupt_event_low i_dut (.I_CLK_SYS(clk), .I_RST_N(rst_n),
        .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr_s), .I_RD(rd_s),
        .O_RDATA(rdata), .I_EVT(evt), .I_CYCLE_SECONDS_COUNTER(sec),
        .I_CYCLE_NUMBER_COUNTER(cnt), .I_LINK_CLOCK_PRESENT(link_ok),
        .I_ISO_RX_EVENT(rx_ev), .I_ISO_RX_MASK(rx_mk), .I_ISO_TX_EVENT(tx_ev),
        .I_ISO_TX_MASK(tx_mk), .O_IRQ(irq), .O_EVENTS(evs));

    task automatic stop_test();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr_s <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_s <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input string n);
        @(posedge clk);
        rd_s <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        chk(n, e, rdata);
    endtask : rd

    task automatic pulse(input logic [14:0] v);
        @(posedge clk);
        evt <= v;
        @(posedge clk);
        evt <= 15'h0;
        #1;
    endtask : pulse

    task automatic ticks(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : ticks

    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        stop_test();
    end

    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        ticks(4);
        rd(OFF_EVENT_SET, 32'h0, "event reset");
        rd(OFF_MASK_SET, 32'h0, "mask reset");
        rd(8'h40, 32'h0, "unmapped read");
        for (int k = 0; k < 12; k++) begin
            pulse(stim[k]);
            chk("event", {10'h0, expv[k]}, {10'h0, evs});
            rd(OFF_EVENT_SET, {10'h0, expv[k]}, "event read");
            wr(OFF_EVENT_CLR, 32'hFFFFFFFF);
            chk("cleared", 32'h0, {10'h0, evs});
        end
        pulse(15'h1000);
        pulse(15'h3000);
        chk("ident on reset", 32'h00028000, {10'h0, evs});
        wr(OFF_EVENT_SET, 32'hFFFFFFFF);
        chk("set all", {10'h0, LATCHED_BITS}, {10'h0, evs});
        rd(OFF_EVENT_SET, {10'h0, LATCHED_BITS}, "set all read");
        @(posedge clk);
        wr_s <= 1'b1;
        addr <= OFF_EVENT_CLR;
        wdata <= 32'h00000100;
        evt <= 15'h0400;
        @(posedge clk);
        wr_s <= 1'b0;
        evt <= 15'h0;
        #1;
        chk("set beats clear", {10'h0, LATCHED_BITS}, {10'h0, evs});
        wr(OFF_EVENT_CLR, 32'h00080000);
        chk("clear one", 32'h0037833F, {10'h0, evs});
        wr(OFF_MASK_SET, 32'h00000100);
        ticks(2);
        chk("irq global off", 32'h0, {31'h0, irq});
        wr(OFF_MASK_SET, 32'h80000000);
        ticks(2);
        chk("irq on", 32'h1, {31'h0, irq});
        rd(OFF_MASK_SET, 32'h80000100, "mask read");
        rd(OFF_EVENT_CLR, 32'h00000100, "masked events");
        wr(OFF_MASK_CLR, 32'h00000100);
        ticks(2);
        chk("irq masked", 32'h0, {31'h0, irq});
        rd(OFF_MASK_CLR, 32'h80000000, "mask clear read");
        wr(OFF_EVENT_CLR, 32'hFFFFFFFF);
        @(posedge clk);
        rx_ev <= 8'h01;
        rx_mk <= 8'h01;
        tx_ev <= 8'h02;
        rd(OFF_EVENT_SET, 32'h00000080, "rx summary");
        tx_mk <= 8'h02;
        rd(OFF_EVENT_SET, 32'h000000C0, "tx summary");
        rx_ev <= 8'h00;
        tx_ev <= 8'h00;
        sec <= 7'h20;
        cnt <= 13'h0002;
        ticks(2);
        chk("timer quiet", 32'h0, {10'h0, evs});
        sec <= 7'h40;
        cnt <= 13'h0003;
        ticks(2);
        chk("timer flags", 32'h00300000, {10'h0, evs});
        wr(OFF_EVENT_CLR, 32'hFFFFFFFF);
        link_ok <= 1'b0;
        ticks(4);
        wr(8'h40, 32'h0);
        ticks(1);
        chk("access failure", 32'h00040000, {10'h0, evs});
        link_ok <= 1'b1;
        stop_test();
    end
endmodule : host_link_interrupt_event_low_tb_top

// ### host_link_irq_monitor.sv
// Assertion checker for the link interrupt event block
`timescale 1ns/10ps
module host_link_irq_monitor
    import host_link_irq_pkg::*;
(
    input wire logic I_CLK_SYS,
    input wire logic I_RST_N,
    input wire logic [ADDR_W-1:0] I_ADDR,
    input wire logic [DATA_W-1:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    input wire logic [DATA_W-1:0] O_RDATA,
    input wire event_strobes_t I_EVT,
    input wire logic [SECONDS_W-1:0] I_CYCLE_SECONDS_COUNTER,
    input wire logic [COUNT_W-1:0] I_CYCLE_NUMBER_COUNTER,
    input wire logic [EVT_W-1:0] O_EVENTS
);
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RST_N);
    logic clr_wr;
    logic set_wr;
    assign clr_wr = I_WR && (I_ADDR == OFF_EVENT_CLR);
    assign set_wr = I_WR && (I_ADDR == OFF_EVENT_SET);
    AST_SECONDS_TICK: assert property ($past(I_RST_N, 2) &&
        $changed(I_CYCLE_SECONDS_COUNTER[SECONDS_WATCH_BIT]) |=> O_EVENTS[21])
        else $error("seconds bit change not flagged");
    AST_NEW_CYCLE: assert property ($past(I_RST_N, 2) &&
        $changed(I_CYCLE_NUMBER_COUNTER[COUNT_WATCH_BIT]) |=> O_EVENTS[20])
        else $error("cycle count toggle not flagged");
    AST_PHY_SET: assert property (I_EVT.phy_request |=> O_EVENTS[19])
        else $error("phy request not flagged");
    AST_BUS_RESET_SET: assert property (
        I_EVT.bus_reset_entered |=> O_EVENTS[17])
        else $error("bus reset not flagged");
    AST_IDENT_DROP: assert property ($rose(O_EVENTS[17]) |-> !O_EVENTS[16])
        else $error("ident done kept on bus reset");
    AST_IDENT_SET: assert property (
        I_EVT.node_ident_done && !I_EVT.bus_reset_entered
        |=> O_EVENTS[16] && O_EVENTS[15]) else $error("ident done not set");
    AST_STICKY_KEPT: assert property (O_EVENTS[15] && !clr_wr |=> O_EVENTS[15])
        else $error("sticky ident done lost");
    AST_RESERVED_ZERO: assert property (
        $past(I_RD) |-> O_RDATA[14:10] == 5'h00)
        else $error("reserved bits read nonzero");
    AST_SET_BEATS_CLEAR: assert property (
        I_EVT.posted_write_error |=> O_EVENTS[8])
        else $error("posted write error lost");
    AST_CTX_QUALIFIED: assert property (
        I_EVT.ctx_done[0] && I_EVT.ctx_irq_req[0] |=> O_EVENTS[0])
        else $error("request transmit done not set");
    AST_CTX_UNQUALIFIED: assert property (!I_EVT.ctx_irq_req[3] &&
        !O_EVENTS[3] && !(set_wr && I_WDATA[3]) |=> !O_EVENTS[3])
        else $error("receive response flag set without request");
    AST_CLEAR_ONE: assert property (
        clr_wr && I_WDATA[4] && !I_EVT.request_packet_stored |=> !O_EVENTS[4])
        else $error("write one to clear failed");
endmodule : host_link_irq_monitor

bind host_link_interrupt_event_low host_link_irq_monitor i_mon (
    .I_CLK_SYS(I_CLK_SYS), .I_RST_N(I_RST_N), .I_ADDR(I_ADDR),
    .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
    .I_EVT(I_EVT), .I_CYCLE_SECONDS_COUNTER(I_CYCLE_SECONDS_COUNTER),
    .I_CYCLE_NUMBER_COUNTER(I_CYCLE_NUMBER_COUNTER), .O_EVENTS(O_EVENTS));

// ### host_link_irq_pkg.sv
// Constants and types for the link interrupt event block
package host_link_irq_pkg;

    // Register port geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register byte addresses
    localparam logic [7:0] OFF_EVENT_SET = 8'h80;
    localparam logic [7:0] OFF_EVENT_CLR = 8'h84;
    localparam logic [7:0] OFF_MASK_SET = 8'h88;
    localparam logic [7:0] OFF_MASK_CLR = 8'h8C;

    // Event field positions
    localparam int B_SIXTY_FOUR_SECOND_TICK = 21;
    localparam int B_NEW_ISO_CYCLE_FLAG = 20;
    localparam int B_PHY_REQUEST = 19;
    localparam int B_REGISTER_ACCESS_FAILURE = 18;
    localparam int B_BUS_RESET_ENTERED = 17;
    localparam int B_NODE_IDENT_DONE = 16;
    localparam int B_NODE_IDENT_DONE_STICKY = 15;
    localparam int B_LOCK_RESPONSE_ERROR = 9;
    localparam int B_POSTED_WRITE_ERROR = 8;
    localparam int B_ISO_RECEIVE_SUMMARY = 7;
    localparam int B_ISO_TRANSMIT_SUMMARY = 6;
    localparam int B_RESPONSE_PACKET_STORED = 5;
    localparam int B_REQUEST_PACKET_STORED = 4;
    localparam int B_ASYNC_RX_RESPONSE_CONTEXT = 3;
    localparam int B_ASYNC_RX_REQUEST_CONTEXT = 2;
    localparam int B_RESPONSE_TRANSMIT_DONE = 1;
    localparam int B_REQUEST_TRANSMIT_DONE = 0;
    localparam int B_GLOBAL_INTERRUPT_ENABLE = 31;

    // Event width of this half and DMA context count
    localparam int EVT_W = 22;
    localparam int ASYNC_CTX = 4;

    // Latched event bits; reserved 14:10 and summaries 7:6 excluded
    localparam logic [21:0] LATCHED_BITS = 22'h3F833F;
    // Summary bits that are computed, never stored
    localparam logic [21:0] SUMMARY_BITS = 22'h0000C0;
    // Mask bits that exist in this half
    localparam logic [21:0] MASK_BITS = 22'h3F83FF;

    // Reset values
    localparam logic [21:0] EVENT_RESET = 22'h000000;
    localparam logic [21:0] MASK_RESET = 22'h000000;
    localparam logic [31:0] RDATA_IDLE = 32'h00000000;

    // Cycle timer field widths and watched bit positions
    localparam int SECONDS_W = 7;
    localparam int SECONDS_WATCH_BIT = 6;
    localparam int COUNT_W = 13;
    localparam int COUNT_WATCH_BIT = 0;

    // Strobes from the link core and the DMA units
    typedef struct packed {
        logic phy_request;
        logic bus_reset_entered;
        logic node_ident_done;
        logic lock_response_error;
        logic posted_write_error;
        logic response_packet_stored;
        logic request_packet_stored;
        logic [3:0] ctx_done;
        logic [3:0] ctx_irq_req;
    } event_strobes_t;

    // Register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

endpackage : host_link_irq_pkg
